//--- host_port_pkg.sv
/*
 * Constants, mode enum and carrier structs for the port.
 * Assumes one core clock plus one link clock.
 */
// What this block does
// R1 - Role pin high selects microcontroller slave role
// R2 - Sync pin picks synchronous or asynchronous SRAM slave
// R3 - Both selects high plus sync gives burst slave
// R4 - Mux pin shares address and data lines
// R5 - Burst slave addresses are byte addresses
// R6 - Shared lane pins: strobes or enables by pin in async SRAM slave; sync SRAM slave always uses enables
// R7 - Board holds strobe function pin low in burst
// R8 - Active-low error output, optionally left unconnected
// R9 - SRAM slave: master wires bit2 or bit1
// R10 - Multiplexed burst: master wires address bit 17
// R11 - Separated burst: master wires boundary bit on bit1
// R12 - Both low: asynchronous SRAM-style memory master
// R13 - Type high, role low: synchronous burst master
// R14 - Burst master with mux pin shares lines
// R15 - Both boot pins low boots chip select zero
// R16 - Paged ROM on-page access on chip select zero
// R17 - Separate paged chip select input in SRAM slave
// R18 - Mode pins latched once after reset, static
package host_port_pkg;

    // ----------------------------------------------------------------
    // Widths and counts
    // ----------------------------------------------------------------
    localparam int DATA_W = 32; // Widest data bus
    localparam int ADDR_W = 24; // Host address pins carried
    localparam int LANES = 4; // Byte lanes on the shared pins
    localparam int LSB_WIDE = 2; // First word address bit, 32-bit bus
    localparam int LSB_NARROW = 1; // First halfword address bit, 16-bit bus
    localparam logic [3:0] SETTLE_CYCLES = 4'h8; // Strap settle after reset
    localparam logic [LANES-1:0] LANES_ALL = 4'hF; // Every lane enabled
    localparam logic [LANES-1:0] LANES_NARROW = 4'h3; // Lanes on 16-bit bus
    localparam logic [ADDR_W-1:0] BEAT_BYTES_WIDE = 24'h000004; // Burst step, 32-bit
    localparam logic [ADDR_W-1:0] BEAT_BYTES_NARROW = 24'h000002; // Burst step, 16-bit

    // ----------------------------------------------------------------
    // Connection modes
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_NONE,
        MEM_ASYNC,
        MEM_SYNC,
        MCU_ASYNC_SRAM,
        MCU_SYNC_SRAM,
        MCU_BURST_SEP,
        MCU_BURST_MUX,
        MODE_PROHIBITED
    } mode_t;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic role; // Interface role select
        logic ctrl_type; // Controller type select
        logic host_sync; // Host sync select
        logic ad_mux; // Address/data mux select
        logic wr_fn; // Write strobe function select
        logic boot_lo; // Boot source select, low bit
        logic boot_hi; // Boot source select, high bit
        logic wide; // 32-bit bus when high
    } straps_t;

    typedef struct packed {
        logic cs_n; // Normal chip select
        logic page_cs_n; // Paged-access chip select
        logic adv_n; // Address phase marker, mux mode
        logic we_n; // Write when lanes are enables
        logic [LANES-1:0] lanes_n; // Shared strobe/enable pins
        logic [ADDR_W-1:0] addr; // Separate address pins
        logic [DATA_W-1:0] data; // Data pins, address too in mux mode
    } pin_sample_t;

    typedef struct packed {
        logic [ADDR_W-1:0] byte_addr; // Byte address of the beat
        logic write; // Write when high
        logic [LANES-1:0] byte_en; // Active-high byte enables
        logic [DATA_W-1:0] wdata; // Write data
        logic paged; // Via paged chip select
    } host_access_t;

    typedef struct packed {
        logic async_en; // Asynchronous memory master active
        logic sync_en; // Synchronous burst master active
        logic mux_en; // Master shares address and data lines
        logic boot_cs0; // Boot fetch from chip select zero
    } master_cfg_t;

endpackage

//--- host_port_mode_select.sv
/*
 * Mode select and host access capture.
 * Latches straps once after reset, decodes the mode,
 * sets up the memory master and turns slave
 * pin activity into access pulses on sys_clk.
 * Assumes static straps, host clock only in
 * synchronous slave modes, async hosts stable
 * until chip select rises.
 */
`timescale 1ns/1ps

module host_port_mode_select (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic host_clk,
    input wire logic interface_role_select,
    input wire logic controller_type_select,
    input wire logic host_sync_select,
    input wire logic addr_data_mux_select,
    input wire logic write_strobe_function_select,
    input wire logic boot_source_sel_lo,
    input wire logic boot_source_sel_hi,
    input wire logic bus_width_32,
    input wire host_port_pkg::pin_sample_t host_pins,
    input wire logic [host_port_pkg::LANES-1:0] page_mode_req,
    input wire logic core_error,
    output logic cfg_valid,
    output host_port_pkg::mode_t mode,
    output host_port_pkg::master_cfg_t master_cfg,
    output logic [host_port_pkg::LANES-1:0] page_mode_cs_en,
    output logic access_valid,
    output host_port_pkg::host_access_t access,
    output logic host_error_out_n
);

    // ----------------------------------------------------------------
    // Access decode shared by both capture paths
    // ----------------------------------------------------------------
    // Lane meaning, write direction and byte address for one sample
    function automatic host_port_pkg::host_access_t decode_access(
        input host_port_pkg::pin_sample_t p,
        input logic [host_port_pkg::ADDR_W-1:0] addr_src,
        input logic burst,
        input logic wr_fn,
        input logic wide
    );
        host_port_pkg::host_access_t a;
        logic [host_port_pkg::LANES-1:0] en;
        logic [1:0] lo;
        a = '0;
        en = '0;
        lo = '0;
        // Strobe meaning only outside burst; burst ignores the pin
        if (wr_fn && !burst) begin // R6 R7
            a.write = ~&p.lanes_n;
            en = a.write ? ~p.lanes_n : host_port_pkg::LANES_ALL;
        end else begin // R6
            a.write = ~p.we_n;
            en = ~p.lanes_n;
        end
        if (!wide) begin
            en = en & host_port_pkg::LANES_NARROW;
        end
        // Lowest enabled lane gives the byte offset inside the word
        for (int i = host_port_pkg::LANES - 1; i >= 0; i--) begin
            if (en[i]) begin
                lo = 2'(i);
            end
        end
        if (burst) begin // R5
            a.byte_addr = addr_src;
        end else if (wide) begin // R9
            a.byte_addr = {addr_src[host_port_pkg::ADDR_W-1:host_port_pkg::LSB_WIDE], lo};
        end else begin // R9
            a.byte_addr = {addr_src[host_port_pkg::ADDR_W-1:host_port_pkg::LSB_NARROW], lo[0]};
        end
        a.byte_en = en;
        a.wdata = p.data;
        a.paged = ~p.page_cs_n; // R17
        return a;
    endfunction

    // ----------------------------------------------------------------
    // Strap capture, sys_clk domain
    // ----------------------------------------------------------------
    host_port_pkg::straps_t strap_pins; // Raw strap levels
    host_port_pkg::straps_t strap_s1_ff; // First sync stage
    host_port_pkg::straps_t strap_s2_ff; // Second sync stage
    host_port_pkg::straps_t straps_ff; // Latched straps
    logic [3:0] settle_ff; // Cycles since reset release
    logic cfg_valid_ff; // Straps latched
    host_port_pkg::mode_t mode_ff; // Latched mode
    host_port_pkg::mode_t nxt_mode; // Mode decoded from synced straps
    logic take_straps; // One-shot latch moment

    assign strap_pins = {interface_role_select, controller_type_select,
                         host_sync_select, addr_data_mux_select,
                         write_strobe_function_select, boot_source_sel_lo,
                         boot_source_sel_hi, bus_width_32};

    // Mode table; low-sync burst setting refused
    assign nxt_mode = !strap_s2_ff.role ?
                      (strap_s2_ff.ctrl_type ? host_port_pkg::MEM_SYNC : host_port_pkg::MEM_ASYNC) : // R12 R13
                      !strap_s2_ff.ctrl_type ?
                      (strap_s2_ff.host_sync ? host_port_pkg::MCU_SYNC_SRAM : host_port_pkg::MCU_ASYNC_SRAM) : // R1 R2
                      !strap_s2_ff.host_sync ? host_port_pkg::MODE_PROHIBITED : // R3
                      (strap_s2_ff.ad_mux ? host_port_pkg::MCU_BURST_MUX : host_port_pkg::MCU_BURST_SEP); // R3 R4

    // Latch once settled; never again until reset
    assign take_straps = !cfg_valid_ff && (settle_ff == host_port_pkg::SETTLE_CYCLES); // R18

    // Two-stage strap synchroniser
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            strap_s1_ff <= '0;
            strap_s2_ff <= '0;
        end else begin
            strap_s1_ff <= strap_pins;
            strap_s2_ff <= strap_s1_ff;
        end
    end

    // Settle counter stops at its target
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            settle_ff <= '0;
        end else if (settle_ff != host_port_pkg::SETTLE_CYCLES) begin
            settle_ff <= settle_ff + 4'h1;
        end
    end

    // One-shot configuration latch
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            straps_ff <= '0;
            mode_ff <= host_port_pkg::MODE_NONE;
            cfg_valid_ff <= 1'b0;
        end else if (take_straps) begin // R18
            straps_ff <= strap_s2_ff;
            mode_ff <= nxt_mode;
            cfg_valid_ff <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Memory master configuration
    // ----------------------------------------------------------------
    logic is_master; // Either memory master mode
    logic is_burst; // Either burst slave mode
    logic is_sync_slave; // Slave modes clocked by host_clk
    host_port_pkg::master_cfg_t nxt_master_cfg; // Master controls
    host_port_pkg::master_cfg_t master_cfg_ff; // Registered master controls
    logic [host_port_pkg::LANES-1:0] page_en_ff; // Page-mode permission per chip select
    logic [host_port_pkg::LANES-1:0] nxt_page_en; // Next page-mode permission

    assign is_master = (mode_ff == host_port_pkg::MEM_ASYNC) || (mode_ff == host_port_pkg::MEM_SYNC);
    assign is_burst = (mode_ff == host_port_pkg::MCU_BURST_SEP) || (mode_ff == host_port_pkg::MCU_BURST_MUX);
    assign is_sync_slave = is_burst || (mode_ff == host_port_pkg::MCU_SYNC_SRAM);

    assign nxt_master_cfg.async_en = (mode_ff == host_port_pkg::MEM_ASYNC); // R12
    assign nxt_master_cfg.sync_en = (mode_ff == host_port_pkg::MEM_SYNC); // R13
    assign nxt_master_cfg.mux_en = (mode_ff == host_port_pkg::MEM_SYNC) && straps_ff.ad_mux; // R14
    assign nxt_master_cfg.boot_cs0 = is_master && !straps_ff.boot_lo && !straps_ff.boot_hi; // R15
    // Only the first chip select may run on-page reads
    assign nxt_page_en = is_master ? {{(host_port_pkg::LANES-1){1'b0}}, page_mode_req[0]} : '0; // R16

    // Master control registers
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            master_cfg_ff <= '0;
            page_en_ff <= '0;
        end else begin
            master_cfg_ff <= nxt_master_cfg;
            page_en_ff <= nxt_page_en;
        end
    end

    // ----------------------------------------------------------------
    // Link clock domain: reset and configuration crossing
    // ----------------------------------------------------------------
    logic host_rst_s1_ff; // Reset release, first stage
    logic host_rst_ff; // Reset for link logic
    logic [1:0] cfg_h_s1_ff; // Sync-mode enable and mux flag, first stage
    logic [1:0] cfg_h_ff; // Same, usable in link domain
    logic [1:0] cfg_to_host; // Static levels from the core side
    logic burst_h_s1_ff; // Burst flag, first stage
    logic burst_h_ff; // Burst flag in link domain
    logic wide_h_s1_ff; // Bus width, first stage
    logic wide_h_ff; // Bus width in link domain

    assign cfg_to_host = {cfg_valid_ff && is_sync_slave, mode_ff == host_port_pkg::MCU_BURST_MUX};

    // Asserts at once, releases on host_clk edges
    always_ff @(posedge host_clk or posedge sys_rst) begin
        if (sys_rst) begin
            host_rst_s1_ff <= 1'b1;
            host_rst_ff <= 1'b1;
        end else begin
            host_rst_s1_ff <= 1'b0;
            host_rst_ff <= host_rst_s1_ff;
        end
    end

    // Static after latch, so level sync suffices
    always_ff @(posedge host_clk or posedge host_rst_ff) begin
        if (host_rst_ff) begin
            cfg_h_s1_ff <= '0;
            cfg_h_ff <= '0;
            burst_h_s1_ff <= 1'b0;
            burst_h_ff <= 1'b0;
            wide_h_s1_ff <= 1'b0;
            wide_h_ff <= 1'b0;
        end else begin
            cfg_h_s1_ff <= cfg_to_host;
            cfg_h_ff <= cfg_h_s1_ff;
            burst_h_s1_ff <= is_burst;
            burst_h_ff <= burst_h_s1_ff;
            wide_h_s1_ff <= straps_ff.wide;
            wide_h_ff <= wide_h_s1_ff;
        end
    end

    // ----------------------------------------------------------------
    // Link clock domain: beat capture and toggle handshake
    // ----------------------------------------------------------------
    logic [host_port_pkg::ADDR_W-1:0] beat_addr_ff; // Running burst address
    host_port_pkg::host_access_t hold_ff; // Beat waiting for the core
    logic req_tgl_ff; // Flips once per offered beat
    logic ack_s1_ff; // Acknowledge, first stage
    logic ack_s2_ff; // Acknowledge in link domain
    logic overrun_ff; // Beat arrived while previous unconsumed
    logic sel_h; // Either chip select active
    logic addr_phase; // Mux address phase
    logic beat_take; // Data beat this edge
    logic busy_h; // Previous beat not yet consumed
    logic [host_port_pkg::ADDR_W-1:0] addr_src_h; // Address used for this beat
    logic [host_port_pkg::ADDR_W-1:0] beat_step; // Bytes per beat
    host_port_pkg::host_access_t beat_h; // Decoded beat

    assign sel_h = !host_pins.cs_n || !host_pins.page_cs_n; // R17
    assign addr_phase = cfg_h_ff[0] && !host_pins.adv_n; // R4
    assign beat_take = cfg_h_ff[1] && sel_h && !addr_phase;
    assign busy_h = req_tgl_ff != ack_s2_ff;
    // Mux walks its latched address; separate uses pins
    assign addr_src_h = cfg_h_ff[0] ? beat_addr_ff : host_pins.addr; // R4 R10 R11
    assign beat_step = wide_h_ff ? host_port_pkg::BEAT_BYTES_WIDE : host_port_pkg::BEAT_BYTES_NARROW;
    assign beat_h = decode_access(host_pins, addr_src_h, burst_h_ff, 1'b0, wide_h_ff);

    // Address latch and advance in mux mode
    always_ff @(posedge host_clk or posedge host_rst_ff) begin
        if (host_rst_ff) begin
            beat_addr_ff <= '0;
        end else if (addr_phase && sel_h) begin // R4
            beat_addr_ff <= host_pins.data[host_port_pkg::ADDR_W-1:0];
        end else if (beat_take) begin // R5
            beat_addr_ff <= beat_addr_ff + beat_step;
        end
    end

    // Offer a beat once the last is consumed
    always_ff @(posedge host_clk or posedge host_rst_ff) begin
        if (host_rst_ff) begin
            hold_ff <= '0;
            req_tgl_ff <= 1'b0;
        end else if (beat_take && !busy_h) begin
            hold_ff <= beat_h;
            req_tgl_ff <= !req_tgl_ff;
        end
    end

    // Sticky overrun; lost beats are reported
    always_ff @(posedge host_clk or posedge host_rst_ff) begin
        if (host_rst_ff) begin
            overrun_ff <= 1'b0;
        end else if (beat_take && busy_h) begin // R8
            overrun_ff <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Core side of the handshake
    // ----------------------------------------------------------------
    logic req_s1_ff; // Request toggle, first stage
    logic req_s2_ff; // Request toggle, usable
    logic req_seen_ff; // Last toggle consumed; also the acknowledge
    logic ovr_s1_ff; // Overrun level, first stage
    logic ovr_s2_ff; // Overrun level, usable
    logic sync_new; // Fresh beat from the link side

    assign sync_new = req_s2_ff != req_seen_ff;

    // Acknowledge back to link domain, two stages
    always_ff @(posedge host_clk or posedge host_rst_ff) begin
        if (host_rst_ff) begin
            ack_s1_ff <= 1'b0;
            ack_s2_ff <= 1'b0;
        end else begin
            ack_s1_ff <= req_seen_ff;
            ack_s2_ff <= ack_s1_ff;
        end
    end

    // Request toggle and overrun level into sys_clk
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            req_s1_ff <= 1'b0;
            req_s2_ff <= 1'b0;
            req_seen_ff <= 1'b0;
            ovr_s1_ff <= 1'b0;
            ovr_s2_ff <= 1'b0;
        end else begin
            req_s1_ff <= req_tgl_ff;
            req_s2_ff <= req_s1_ff;
            req_seen_ff <= req_s2_ff;
            ovr_s1_ff <= overrun_ff;
            ovr_s2_ff <= ovr_s1_ff;
        end
    end

    // ----------------------------------------------------------------
    // Asynchronous SRAM slave path, sys_clk domain
    // ----------------------------------------------------------------
    host_port_pkg::pin_sample_t pin_s1_ff; // First stage
    host_port_pkg::pin_sample_t pin_s2_ff; // Second stage
    host_port_pkg::pin_sample_t pin_s3_ff; // Previous usable sample
    logic sel_s2; // Selected now
    logic sel_s3; // Selected one cycle ago
    logic async_end; // Chip select just released
    host_port_pkg::host_access_t async_acc; // Decoded async access

    assign sel_s2 = !pin_s2_ff.cs_n || !pin_s2_ff.page_cs_n; // R17
    assign sel_s3 = !pin_s3_ff.cs_n || !pin_s3_ff.page_cs_n;
    // Taken at release, when write data has settled
    assign async_end = cfg_valid_ff && (mode_ff == host_port_pkg::MCU_ASYNC_SRAM) && sel_s3 && !sel_s2; // R2
    assign async_acc = decode_access(pin_s3_ff, pin_s3_ff.addr, 1'b0, straps_ff.wr_fn, straps_ff.wide); // R6 R9

    // Whole pin bundle runs through the chain; bus skew costs one cycle
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_s1_ff <= '1;
            pin_s2_ff <= '1;
            pin_s3_ff <= '1;
        end else begin
            pin_s1_ff <= host_pins;
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
        end
    end

    // ----------------------------------------------------------------
    // Access output and error pin
    // ----------------------------------------------------------------
    logic access_valid_ff; // One-cycle access pulse
    host_port_pkg::host_access_t access_ff; // Access fields
    logic error_n_ff; // Error pin level
    logic nxt_error_n; // Error pin next
    logic nxt_valid; // Access pulse next

    assign nxt_valid = async_end || (sync_new && cfg_valid_ff && is_sync_slave);
    // Prohibited straps, lost beats or core faults outside master modes pull the pin low
    assign nxt_error_n = !(cfg_valid_ff && ((mode_ff == host_port_pkg::MODE_PROHIBITED) || ovr_s2_ff ||
                                            (!is_master && core_error))); // R3 R8

    // Hold is stable until acknowledged
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            access_valid_ff <= 1'b0;
            access_ff <= '0;
        end else begin
            access_valid_ff <= nxt_valid;
            if (async_end) begin
                access_ff <= async_acc;
            end else if (nxt_valid) begin
                access_ff <= hold_ff;
            end
        end
    end

    // Error pin register, high while idle
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            error_n_ff <= 1'b1;
        end else begin
            error_n_ff <= nxt_error_n; // R8
        end
    end

    assign cfg_valid = cfg_valid_ff;
    assign mode = mode_ff;
    assign master_cfg = master_cfg_ff;
    assign page_mode_cs_en = page_en_ff;
    assign access_valid = access_valid_ff;
    assign access = access_ff;
    assign host_error_out_n = error_n_ff;

endmodule

//--- host_port_mode_select_properties.sv
/* Checker for the mode-select block, bound to its top ports.
   Assumes the straps stay fixed from reset onward. */
`timescale 1ns/1ps
module host_port_mode_select_properties (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic interface_role_select,
    input wire logic controller_type_select,
    input wire logic host_sync_select,
    input wire logic addr_data_mux_select,
    input wire logic boot_source_sel_lo,
    input wire logic boot_source_sel_hi,
    input wire logic cfg_valid,
    input wire host_port_pkg::mode_t mode,
    input wire host_port_pkg::master_cfg_t master_cfg,
    input wire logic [host_port_pkg::LANES-1:0] page_mode_cs_en,
    input wire logic host_error_out_n
);
    // ----------------
    // Decode and hold
    // ----------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    wire logic role = interface_role_select; // Short aliases
    wire logic ctype = controller_type_select;
    wire logic sel3 = role && ctype && host_sync_select;
    chk_role_slave: assert property (cfg_valid && role |-> mode > host_port_pkg::MEM_SYNC)
        else $error("slave role not decoded");
    chk_sram_kind: assert property (cfg_valid && role && !ctype |-> mode == (host_sync_select ?
        host_port_pkg::MCU_SYNC_SRAM : host_port_pkg::MCU_ASYNC_SRAM)) else $error("sram slave kind wrong");
    chk_burst_kind: assert property (cfg_valid && sel3 |-> mode == (addr_data_mux_select ?
        host_port_pkg::MCU_BURST_MUX : host_port_pkg::MCU_BURST_SEP)) else $error("burst kind wrong");
    chk_master_kind: assert property (cfg_valid && !role |-> mode == (ctype ?
        host_port_pkg::MEM_SYNC : host_port_pkg::MEM_ASYNC)) else $error("master kind wrong");
    chk_mode_hold: assert property (cfg_valid |=> cfg_valid && $stable(mode))
        else $error("mode changed in operation");
    chk_prohib_err: assert property (cfg_valid && role && ctype && !host_sync_select |=> (!host_error_out_n)[*3])
        else $error("prohibited setting not flagged");
    chk_boot_zero: assert property ($past(cfg_valid, 2) |-> master_cfg.boot_cs0 ==
        (!role && !boot_source_sel_lo && !boot_source_sel_hi)) else $error("boot select wrong");
    chk_page_zero: assert property ($past(cfg_valid, 2) |-> page_mode_cs_en[3:1] == 3'h0 &&
        master_cfg.mux_en == (!role && ctype && addr_data_mux_select)) else $error("page or mux enable wrong");
endmodule
bind host_port_mode_select host_port_mode_select_properties host_port_mode_select_properties_i (.sys_clk, .sys_rst,
    .interface_role_select, .controller_type_select, .host_sync_select, .addr_data_mux_select, .boot_source_sel_lo,
    .boot_source_sel_hi, .cfg_valid, .mode, .master_cfg, .page_mode_cs_en, .host_error_out_n);

//--- host_master_model.sv
/* External master model: host pins and link clock.
   Assumes one call at a time; clock idle between frames. */
`timescale 1ns/1ps
module host_master_model (
    output logic host_clk,
    output host_port_pkg::pin_sample_t host_pins
);
    // Idle: deselected, paged select unused
    initial begin
        host_clk = 1'b0;
        host_pins = '1;
    end
    // One 6 ns link clock period
    task automatic tick();
        #3 host_clk = 1'b1;
        #3 host_clk = 1'b0;
    endtask
    // Async write; select held 4 core cycles
    task automatic sram_write(input logic [23:0] a, input logic [31:0] d, input logic [3:0] ln);
        host_pins = {4'h7, ln, a, d};
        #40 host_pins = {4'hF, 4'hF, a, ~d};
    endtask
    // Muxed burst write: address phase then one beat
    task automatic burst_write(input logic [23:0] a, input logic [31:0] d, input logic [3:0] ln);
        host_pins = {4'h5, 4'hF, 24'hFFFFFF, 8'h00, a};
        tick();
        host_pins = {4'h6, ln, 24'hFFFFFF, d};
        tick();
        host_pins = {4'hF, 4'hF, 24'hFFFFFF, ~d};
    endtask
endmodule

//--- host_port_mode_select_bench.sv
/* Bench: strap table, async and burst writes.
   Assumes the model acts as the external master. */
`timescale 1ns/1ps
module host_port_mode_select_bench;
    logic sys_clk, sys_rst, host_clk, core_error, cfg_valid, access_valid, host_error_out_n;
    logic [3:0] page_mode_req, page_mode_cs_en;
    host_port_pkg::straps_t st; // Strap levels
    host_port_pkg::pin_sample_t host_pins;
    host_port_pkg::mode_t mode;
    host_port_pkg::master_cfg_t master_cfg;
    host_port_pkg::host_access_t access;
    int error_cnt = 0;
    int check_count = 0;
    host_master_model host_master_model_i (.host_clk, .host_pins);
    host_port_mode_select host_port_mode_select_i (.sys_clk, .sys_rst, .host_clk,
        .interface_role_select(st.role), .controller_type_select(st.ctrl_type), .host_sync_select(st.host_sync),
        .addr_data_mux_select(st.ad_mux), .write_strobe_function_select(st.wr_fn), .boot_source_sel_lo(st.boot_lo),
        .boot_source_sel_hi(st.boot_hi), .bus_width_32(st.wide), .host_pins, .page_mode_req, .core_error,
        .cfg_valid, .mode, .master_cfg, .page_mode_cs_en, .access_valid, .access, .host_error_out_n);
    // Compare and count
    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Reset with new straps
    task automatic boot(input logic [7:0] s);
        @(negedge sys_clk);
        sys_rst = 1'b1;
        st = s;
        repeat (4) host_master_model_i.tick();
        repeat (20) @(negedge sys_clk);
        sys_rst = 1'b0;
        for (int i = 0; i < 30 && cfg_valid !== 1'b1; i++) @(negedge sys_clk);
        repeat (2) @(negedge sys_clk);
    endtask
    // Bounded wait for one access pulse
    task automatic wait_access();
        for (int i = 0; i < 40 && access_valid !== 1'b1; i++) @(negedge sys_clk);
        cmp(access_valid, 1'b1);
    endtask
    // Mode, master config, page enables
    task automatic mode_case(input logic [7:0] s, input host_port_pkg::mode_t e);
        boot(s);
        cmp(mode, e);
        cmp({master_cfg, page_mode_cs_en}, {!s[7] && !s[6], !s[7] && s[6], !s[7] && s[6] && s[4],
            !s[7] && s[2:1] == 2'h0, 3'h0, !s[7]});
        cmp(host_error_out_n, e != host_port_pkg::MODE_PROHIBITED);
    endtask
    // Async write via strobes
    task automatic async_case();
        boot(8'h89);
        host_master_model_i.sram_write(24'h000105, 32'hA5C30F96, 4'hB);
        wait_access();
        cmp(access, {24'h000106, 1'b1, 4'h4, 32'hA5C30F96, 1'b0});
    endtask
    // Muxed burst beat, strobe pin held low, then core error
    task automatic burst_case();
        boot(8'hF1);
        repeat (5) host_master_model_i.tick();
        host_master_model_i.burst_write(24'h020011, 32'h12345678, 4'h0);
        wait_access();
        cmp(access, {24'h020011, 1'b1, 4'hF, 32'h12345678, 1'b0});
        core_error = 1'b1;
        repeat (3) @(negedge sys_clk);
        cmp(host_error_out_n, 1'b0);
    endtask
    // Verdict
    task automatic summarize();
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        #100000;
        error_cnt++;
        summarize();
    end
    initial begin
        sys_rst = 1'b1;
        st = '0;
        page_mode_req = 4'hF;
        core_error = 1'b0;
        mode_case(8'h01, host_port_pkg::MEM_ASYNC);
        mode_case(8'h03, host_port_pkg::MEM_ASYNC);
        mode_case(8'h51, host_port_pkg::MEM_SYNC);
        mode_case(8'h41, host_port_pkg::MEM_SYNC);
        mode_case(8'h81, host_port_pkg::MCU_ASYNC_SRAM);
        mode_case(8'hA1, host_port_pkg::MCU_SYNC_SRAM);
        mode_case(8'hC1, host_port_pkg::MODE_PROHIBITED);
        mode_case(8'hE1, host_port_pkg::MCU_BURST_SEP);
        mode_case(8'hF1, host_port_pkg::MCU_BURST_MUX);
        async_case();
        burst_case();
        summarize();
    end
endmodule
